// ===== dv/sfi_chk.sv
// Purpose: port timing checks on sfi_top
// Assumes: one clock, async reset
// Notes:   wait length kept in a counter, too long for a repetition
`timescale 1ns/1ps
module sfi_chk #(
  parameter [31:0] BIT_CYC  = 4,
  parameter [31:0] WAIT_CYC = 100
) (
  input wire        CLK,
  input wire        RST,
  input wire        STAGE_VLD,
  input wire [7:0]  STAGE_CODE,
  input wire        TEST_DONE,
  input wire        RETURN_KEY,
  input wire        EVT_VLD,
  input wire [7:0]  LED,
  input wire        BEEP_ON,
  input wire        BEEP_HIGH,
  input wire        PROMPT_RISK,
  input wire        PROMPT_WAIT,
  input wire        SCAN_START,
  input wire        ATTENDED,
  input wire        AUTO_BOOT,
  input wire        REPORT_VLD,
  input wire [31:0] REPORT_ADDR
);
  reg        done_r;
  reg [31:0] wcnt_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // test phase flag and cycles spent in the wait prompt
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      done_r <= 1'b0;
      wcnt_r <= 32'h0;
    end else begin
      done_r <= done_r | TEST_DONE;
      wcnt_r <= PROMPT_WAIT ? wcnt_r + 32'h1 : 32'h0;
    end
  end
  property p_evt; EVT_VLD |=> REPORT_VLD && REPORT_ADDR[31:12] == 20'hfffff; endproperty
  a_evt: assert property (p_evt) else $error("event not reported");
  property p_stg; STAGE_VLD && !TEST_DONE && !done_r |=> LED == $past(STAGE_CODE); endproperty
  a_stg: assert property (p_stg) else $error("stage not shown");
  property p_ret; RETURN_KEY && (PROMPT_WAIT || PROMPT_RISK)
    |=> ATTENDED && SCAN_START && !BEEP_ON && !AUTO_BOOT; endproperty
  a_ret: assert property (p_ret) else $error("return not taken");
  property p_risk; PROMPT_RISK && !RETURN_KEY |=> PROMPT_RISK; endproperty
  a_risk: assert property (p_risk) else $error("risk prompt left");
  property p_wmax; PROMPT_WAIT |-> wcnt_r < WAIT_CYC; endproperty
  a_wmax: assert property (p_wmax) else $error("wait too long");
  property p_tmo; $fell(PROMPT_WAIT) && !$past(RETURN_KEY)
    |-> wcnt_r == WAIT_CYC && SCAN_START && AUTO_BOOT; endproperty
  a_tmo: assert property (p_tmo) else $error("bad timeout");
  property p_tone; $rose(BEEP_ON) |-> BEEP_HIGH == LED[6]; endproperty
  a_tone: assert property (p_tone) else $error("first tone wrong");
  property p_blen; $fell(BEEP_ON) && PROMPT_WAIT |-> wcnt_r == 7 * BIT_CYC; endproperty
  a_blen: assert property (p_blen) else $error("beep length wrong");
endmodule
bind sfi_top sfi_chk #(.BIT_CYC(BIT_CYC), .WAIT_CYC(WAIT_CYC)) chk_i (.*);

// ===== dv/sfi_oper.sv
// Purpose: operator model: return key and an ear on the beeper
// Assumes: bit length given as BIT_CYC
// Notes:   tones taken mid-bit, clear of the tone changes
`timescale 1ns/1ps
module sfi_oper #(
  parameter [31:0] BIT_CYC = 4
) (
  input  wire       CLK,
  input  wire       RST,
  input  wire       BEEP_ON,
  input  wire       BEEP_HIGH,
  output reg        RETURN_KEY,
  output reg  [6:0] TONES
);
  reg [31:0] len_r;
  initial RETURN_KEY = 1'b0;
  // one-cycle press from a falling edge
  task press;
    begin
      RETURN_KEY = 1'b1;
      @(negedge CLK);
      RETURN_KEY = 1'b0;
    end
  endtask
  // shift in the tone heard in each bit
  always @(posedge CLK) begin
    if (RST) begin
      len_r <= 32'h0;
      TONES <= 7'h00;
    end else if (BEEP_ON === 1'b1) begin
      len_r <= len_r + 32'h1;
      if (len_r % BIT_CYC == BIT_CYC / 2)
        TONES <= {TONES[5:0], BEEP_HIGH};
    end
  end
endmodule

// ===== dv/sfi_tb.sv
// Purpose: self-checking bench for sfi_top
// Assumes: bit and wait counts shrunk to 4 and 100 cycles
// Notes:   inputs move on the falling edge
`timescale 1ns/1ps
module testbench;
  localparam BC = 4;
  localparam WC = 100;
  localparam [227:0] TBL = 228'hffaff4ffefe8fe2fdcfd6fcafc4f1cf3af34f2ef28f22f1ceecee6ee0;
  reg         CLK = 1'b0, RST = 1'b1, STAGE_VLD = 1'b0, FAIL_VLD = 1'b0;
  reg         FAIL_CSUM = 1'b0, TEST_DONE = 1'b0, EVT_VLD = 1'b0;
  reg  [7:0]  STAGE_CODE = 8'h00, FAIL_CODE = 8'h00;
  reg  [1:0]  FAIL_PRIO = 2'h0;
  reg  [4:0]  EVT_KIND = 5'h00;
  reg  [3:0]  EVT_IDX = 4'h0;
  wire        RETURN_KEY, BEEP_ON, BEEP_HIGH, PROMPT_RISK, PROMPT_WAIT;
  wire        SCAN_START, ATTENDED, AUTO_BOOT, REPORT_VLD;
  wire [7:0]  LED;
  wire [31:0] REPORT_ADDR;
  wire [6:0]  TONES;
  integer     miscompares = 0, compares = 0, cyc = 0, n;
  sfi_top #(.BIT_CYC(BC), .WAIT_CYC(WC)) uut (.*);
  sfi_oper #(.BIT_CYC(BC)) oper (.*);
  initial forever #20 CLK = ~CLK;
  // hang guard, far above the few hundred cycles needed
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      results;
    end
  end
  task chk(input [32:0] seen, input [32:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (miscompares == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task rst8;
    begin
      RST = 1'b1;
      repeat (8) @(negedge CLK);
      RST = 1'b0;
    end
  endtask
  // valid stays up between calls, so back to back failures need no gap
  task fail(input [7:0] c, input [1:0] p, input s);
    begin
      FAIL_VLD = 1'b1;
      FAIL_CODE = c;
      FAIL_PRIO = p;
      FAIL_CSUM = s;
      @(negedge CLK);
    end
  endtask
  task fin;
    begin
      FAIL_VLD = 1'b0;
      STAGE_VLD = 1'b0;
      TEST_DONE = 1'b1;
      @(negedge CLK);
      TEST_DONE = 1'b0;
    end
  endtask
  task ev(input [4:0] k, input [3:0] i, input [11:0] c);
    begin
      EVT_VLD = 1'b1;
      EVT_KIND = k;
      EVT_IDX = i;
      @(negedge CLK);
      chk({REPORT_VLD, REPORT_ADDR}, {1'b1, 20'hfffff, c});
    end
  endtask
  task t_clean;
    begin
      rst8;
      STAGE_VLD = 1'b1;
      STAGE_CODE = 8'h81;
      @(negedge CLK);
      chk(LED, 8'h81);
      STAGE_CODE = 8'h3c;
      @(negedge CLK);
      chk(LED, 8'h3c);
      fin;
      chk({LED, SCAN_START, AUTO_BOOT, BEEP_ON}, {8'h00, 3'h6});
    end
  endtask
  task t_tmo;
    begin
      rst8;
      fail(8'h12, 2'h1, 1'b0);
      fail(8'h45, 2'h2, 1'b0);
      fail(8'h7f, 2'h2, 1'b0);
      fail(8'h33, 2'h0, 1'b0);
      fin;
      chk({LED, PROMPT_WAIT, PROMPT_RISK, BEEP_ON}, {8'h45, 3'h5});
      n = 1;
      while (SCAN_START !== 1'b1 && n < 300) begin
        @(negedge CLK);
        n = n + 1;
      end
      chk(n, WC + 1);
      chk({AUTO_BOOT, ATTENDED, PROMPT_WAIT, BEEP_ON}, 4'h8);
      chk(TONES, 7'h45);
    end
  endtask
  task t_risk;
    begin
      rst8;
      fail(8'h2d, 2'h1, 1'b1);
      fin;
      repeat (WC + 10) @(negedge CLK);
      chk({LED, PROMPT_RISK, PROMPT_WAIT, SCAN_START}, {8'h2d, 3'h4});
      oper.press;
      chk({ATTENDED, AUTO_BOOT, PROMPT_RISK, SCAN_START}, 4'h9);
    end
  endtask
  // return in the middle of the beep: tone stops and the minute wait is gone
  task t_ret;
    begin
      rst8;
      fail(8'h0a, 2'h3, 1'b0);
      fin;
      repeat (5) @(negedge CLK);
      chk({BEEP_ON, PROMPT_WAIT}, 2'h3);
      oper.press;
      chk({BEEP_ON, PROMPT_WAIT, ATTENDED, AUTO_BOOT, SCAN_START}, 5'h05);
      repeat (WC + 5) @(negedge CLK);
      chk({BEEP_ON, SCAN_START, AUTO_BOOT, ATTENDED, LED}, {4'h1, 8'h0a});
    end
  endtask
  task t_evt;
    begin
      for (n = 0; n < 19; n = n + 1)
        ev(n[4:0], 4'h0, TBL[227 - 12 * n -: 12]);
      for (n = 1; n < 8; n = n + 1)
        ev(5'h09, n[3:0], 12'hfc4 - 12'h006 * n[11:0]);
      ev(5'h0a, 4'hf, 12'hf94);
      ev(5'h10, 4'h7, 12'hf16);
      ev(5'h1f, 4'h0, 12'hee6);
      EVT_VLD = 1'b0;
    end
  endtask
  initial begin
    t_clean;
    t_tmo;
    t_risk;
    t_ret;
    t_evt;
    results;
  end
endmodule

// ===== logic/sfi_regs.vh
// Purpose: constants for the self-test fault indicator
// Assumes: 25 MHz system clock
// Notes:   event codes are the low three hex digits of the report address
`ifndef SFI_REGS_VH
`define SFI_REGS_VH

// timing
`define SFI_CLK_HZ      25000000
`define SFI_BIT_S       1
`define SFI_WAIT_S      60
`define SFI_BEEP_MSB    3'h6
`define SFI_LED_OFF     8'h00

// states
`define SFI_ST_TEST     2'h0
`define SFI_ST_WAIT     2'h1
`define SFI_ST_RISK     2'h2
`define SFI_ST_BOOT     2'h3

// report address layout
`define SFI_ADDR_HI     20'hfffff
`define SFI_STEP        12'h006

// event kinds on EVT_KIND
`define SFI_EV_BUS      5'h00
`define SFI_EV_ADDR     5'h01
`define SFI_EV_ILL      5'h02
`define SFI_EV_ZDIV     5'h03
`define SFI_EV_CHK      5'h04
`define SFI_EV_TRAPV    5'h05
`define SFI_EV_PRIV     5'h06
`define SFI_EV_OP1010   5'h07
`define SFI_EV_OP1111   5'h08
`define SFI_EV_AUTOVEC  5'h09
`define SFI_EV_TRAP     5'h0a
`define SFI_EV_KBRST    5'h0b
`define SFI_EV_KBTMO    5'h0c
`define SFI_EV_BATT     5'h0d
`define SFI_EV_NMI      5'h0e
`define SFI_EV_SPUR     5'h0f
`define SFI_EV_VECT     5'h10
`define SFI_EV_FMT      5'h11
`define SFI_EV_COPROC   5'h12

// event codes
`define SFI_C_BUS       12'hffa
`define SFI_C_ADDR      12'hff4
`define SFI_C_ILL       12'hffe
`define SFI_C_ZDIV      12'hfe8
`define SFI_C_CHK       12'hfe2
`define SFI_C_TRAPV     12'hfdc
`define SFI_C_PRIV      12'hfd6
`define SFI_C_OP1010    12'hfca
`define SFI_C_OP1111    12'hfc4
`define SFI_C_LVL1      12'hfbe
`define SFI_C_TRAP0     12'hf3a
`define SFI_C_KBRST     12'hf34
`define SFI_C_KBTMO     12'hf2e
`define SFI_C_BATT      12'hf28
`define SFI_C_NMI       12'hf22
`define SFI_C_SPUR      12'hf1c
`define SFI_C_VECT0     12'heec
`define SFI_C_FMT       12'hee6
`define SFI_C_COPROC    12'hee0

`endif

// ===== logic/sfi_top.v
// Purpose: power-up self-test fault indicator: leds, beeper, wait, event codes
// Assumes: all inputs but the asynchronous RST synchronous to CLK; strobes are one-cycle pulses
// Notes:   long second/minute counts are parameters so simulation can shrink them
`timescale 1ns/1ps
`include "sfi_regs.vh"

// Operation
// [R1] leds follow test stage while testing
// [R2] no failure: leds off, scan at once
// [R3] keep failures, show highest priority one
// [R4] beep low 7 bits msb first, 1 s each
// [R5] zero low tone, one high tone
// [R6] checksum failure: risk prompt, wait for return
// [R7] other failure: wait prompt, one-minute timeout
// [R8] return stops beep and cancels wait
// [R9] return sets attended mode
// [R10] unattended timeout boots first system found
// [R11] report address upper digits fffff
// [R12] range entries spaced six apart
// [R13] autovector levels fbe down to f9a
// [R14] keyboard reset, timeout, battery codes
// [R15] nmi, spurious, vectored range codes
// [R16] format error and coprocessor codes
// [R17] ties keep earliest stored failure
module sfi_top #(
  parameter [31:0] BIT_CYC  = `SFI_BIT_S * `SFI_CLK_HZ,
  parameter [31:0] WAIT_CYC = `SFI_WAIT_S * `SFI_CLK_HZ
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire        STAGE_VLD,
  input  wire [7:0]  STAGE_CODE,
  input  wire        FAIL_VLD,
  input  wire [7:0]  FAIL_CODE,
  input  wire [1:0]  FAIL_PRIO,
  input  wire        FAIL_CSUM,
  input  wire        TEST_DONE,
  input  wire        RETURN_KEY,
  input  wire        EVT_VLD,
  input  wire [4:0]  EVT_KIND,
  input  wire [3:0]  EVT_IDX,
  output reg  [7:0]  LED,
  output reg         BEEP_ON,
  output reg         BEEP_HIGH,
  output reg         PROMPT_RISK,
  output reg         PROMPT_WAIT,
  output reg         SCAN_START,
  output reg         ATTENDED,
  output reg         AUTO_BOOT,
  output reg         REPORT_VLD,
  output reg  [31:0] REPORT_ADDR
);

  reg  [1:0]  state_r;
  reg         best_vld_r;
  reg  [7:0]  best_code_r;
  reg  [1:0]  best_prio_r;
  reg         best_csum_r;
  reg  [2:0]  bit_idx_r;
  reg  [31:0] bit_cnt_r;
  reg  [31:0] wait_cnt_r;

  wire        fail_win;
  wire [7:0]  fin_code;
  wire        fin_csum;
  wire        fin_any;
  wire [2:0]  bit_nxt;
  wire        bit_end;

  // step n entries along a range from its base code
  function [11:0] sfi_step;
    input [11:0] base;
    input [3:0]  n;
    input        down;
    reg   [11:0] ofs;
    begin
      ofs = `SFI_STEP * {8'h00, n};
      if (down) begin
        sfi_step = base - ofs;
      end else begin
        sfi_step = base + ofs;
      end
    end
  endfunction

  // event kind to low three hex digits of the report address
  function [11:0] sfi_evt_code;
    input [4:0] kind;
    input [3:0] idx;
    begin
      case (kind)
        `SFI_EV_BUS:     sfi_evt_code = `SFI_C_BUS;
        `SFI_EV_ADDR:    sfi_evt_code = `SFI_C_ADDR;
        `SFI_EV_ILL:     sfi_evt_code = `SFI_C_ILL;
        `SFI_EV_ZDIV:    sfi_evt_code = `SFI_C_ZDIV;
        `SFI_EV_CHK:     sfi_evt_code = `SFI_C_CHK;
        `SFI_EV_TRAPV:   sfi_evt_code = `SFI_C_TRAPV;
        `SFI_EV_PRIV:    sfi_evt_code = `SFI_C_PRIV;
        `SFI_EV_OP1010:  sfi_evt_code = `SFI_C_OP1010;
        `SFI_EV_OP1111:  sfi_evt_code = `SFI_C_OP1111;
        // level 0 or above 7 is no real level: spurious
        `SFI_EV_AUTOVEC: begin
          if (idx == 4'h0 || idx > 4'h7) begin
            sfi_evt_code = `SFI_C_SPUR;
          end else begin
            sfi_evt_code = sfi_step(`SFI_C_LVL1, idx - 4'h1, 1'b1); // R13 R12
          end
        end
        `SFI_EV_TRAP:    sfi_evt_code = sfi_step(`SFI_C_TRAP0, idx, 1'b0); // R12
        `SFI_EV_KBRST:   sfi_evt_code = `SFI_C_KBRST; // R14
        `SFI_EV_KBTMO:   sfi_evt_code = `SFI_C_KBTMO; // R14
        `SFI_EV_BATT:    sfi_evt_code = `SFI_C_BATT; // R14
        `SFI_EV_NMI:     sfi_evt_code = `SFI_C_NMI; // R15
        `SFI_EV_SPUR:    sfi_evt_code = `SFI_C_SPUR; // R15
        // only eight vectored slots exist, so the top index bit is dropped
        `SFI_EV_VECT:    sfi_evt_code = sfi_step(`SFI_C_VECT0, {1'b0, idx[2:0]}, 1'b0); // R15
        `SFI_EV_FMT:     sfi_evt_code = `SFI_C_FMT; // R16
        `SFI_EV_COPROC:  sfi_evt_code = `SFI_C_COPROC; // R16
        default:         sfi_evt_code = `SFI_C_FMT; // R16
      endcase
    end
  endfunction

  // a failure in the done cycle still counts; strict compare keeps the earliest
  assign fail_win = FAIL_VLD && (!best_vld_r || FAIL_PRIO > best_prio_r); // R17
  assign fin_code = fail_win ? FAIL_CODE : best_code_r;
  assign fin_csum = fail_win ? FAIL_CSUM : best_csum_r;
  assign fin_any  = fail_win || best_vld_r;
  assign bit_nxt  = bit_idx_r - 3'h1;
  assign bit_end  = (bit_cnt_r == BIT_CYC - 32'h1);

  // failure store, only during test
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      best_vld_r  <= 1'b0;
      best_code_r <= 8'h00;
      best_prio_r <= 2'h0;
      best_csum_r <= 1'b0;
    end else if (state_r == `SFI_ST_TEST && fail_win) begin
      best_vld_r  <= 1'b1; // R3
      best_code_r <= FAIL_CODE; // R3
      best_prio_r <= FAIL_PRIO;
      best_csum_r <= FAIL_CSUM;
    end
  end

  // sequencer: test, failure wait, risk wait, boot scan
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r     <= `SFI_ST_TEST;
      LED         <= `SFI_LED_OFF;
      BEEP_ON     <= 1'b0;
      BEEP_HIGH   <= 1'b0;
      PROMPT_RISK <= 1'b0;
      PROMPT_WAIT <= 1'b0;
      SCAN_START  <= 1'b0;
      ATTENDED    <= 1'b0;
      AUTO_BOOT   <= 1'b0;
      bit_idx_r   <= 3'h0;
      bit_cnt_r   <= 32'h0;
      wait_cnt_r  <= 32'h0;
    end else begin
      SCAN_START <= 1'b0;
      case (state_r)
        `SFI_ST_TEST: begin
          if (TEST_DONE && !fin_any) begin
            LED        <= `SFI_LED_OFF; // R2
            SCAN_START <= 1'b1; // R2
            AUTO_BOOT  <= 1'b1;
            state_r    <= `SFI_ST_BOOT;
          end else if (TEST_DONE) begin
            LED         <= fin_code; // R3
            BEEP_ON     <= 1'b1; // R4
            BEEP_HIGH   <= fin_code[6]; // R4 R5
            bit_idx_r   <= `SFI_BEEP_MSB;
            bit_cnt_r   <= 32'h0;
            wait_cnt_r  <= 32'h0;
            PROMPT_RISK <= fin_csum; // R6
            PROMPT_WAIT <= !fin_csum; // R7
            state_r     <= fin_csum ? `SFI_ST_RISK : `SFI_ST_WAIT;
          end else if (STAGE_VLD) begin
            LED <= STAGE_CODE; // R1
          end
        end
        `SFI_ST_WAIT, `SFI_ST_RISK: begin
          // return wins over a timeout landing in the same cycle
          if (RETURN_KEY) begin
            BEEP_ON     <= 1'b0; // R8
            PROMPT_RISK <= 1'b0;
            PROMPT_WAIT <= 1'b0; // R8
            ATTENDED    <= 1'b1; // R9
            AUTO_BOOT   <= 1'b0; // R9
            SCAN_START  <= 1'b1; // R6
            state_r     <= `SFI_ST_BOOT;
          end else if (state_r == `SFI_ST_WAIT && wait_cnt_r == WAIT_CYC - 32'h1) begin
            BEEP_ON     <= 1'b0;
            PROMPT_WAIT <= 1'b0; // R7
            AUTO_BOOT   <= 1'b1; // R10
            SCAN_START  <= 1'b1; // R7
            state_r     <= `SFI_ST_BOOT;
          end else begin
            // risk wait has no timeout; its counter simply idles
            if (state_r == `SFI_ST_WAIT) begin
              wait_cnt_r <= wait_cnt_r + 32'h1; // R7
            end
            if (BEEP_ON) begin
              bit_cnt_r <= bit_end ? 32'h0 : bit_cnt_r + 32'h1; // R4
              if (bit_end && bit_idx_r == 3'h0) begin
                BEEP_ON <= 1'b0; // R4
              end else if (bit_end) begin
                bit_idx_r <= bit_nxt; // R4
                BEEP_HIGH <= LED[bit_nxt]; // R5
              end
            end
          end
        end
        `SFI_ST_BOOT: begin
          state_r <= `SFI_ST_BOOT;
        end
        default: begin
          state_r <= `SFI_ST_TEST;
        end
      endcase
    end
  end

  // unexpected event reporting, one cycle after the strobe
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      REPORT_VLD  <= 1'b0;
      REPORT_ADDR <= 32'h0;
    end else begin
      REPORT_VLD <= EVT_VLD;
      if (EVT_VLD) begin
        REPORT_ADDR <= {`SFI_ADDR_HI, sfi_evt_code(EVT_KIND, EVT_IDX)}; // R11
      end
    end
  end

endmodule
